// ---- gtc_defines.svh ----
// Purpose: Offsets, fields, reset values and codes of the guard timer
// Assumes: 8-bit AXI4-Lite byte addresses, 32-bit data
// Notes: Definitions only
`ifndef GTC_DEFINES_SVH
`define GTC_DEFINES_SVH

// ==================================================
// Register byte offsets
`define GTC_OFS_CTRL 8'h00
`define GTC_OFS_IRQ_STATUS 8'h04
`define GTC_OFS_IRQ_MASK 8'h08
`define GTC_OFS_COUNT 8'h0c

// ==================================================
// Control register fields
`define GTC_PRE_MSB 7
`define GTC_PRE_LSB 4
`define GTC_RESP_BIT 3
`define GTC_FLAG_BIT 2
`define GTC_RUN_BIT 1
`define GTC_UNLOCK_BIT 0

// ==================================================
// Reset values
`define GTC_CTRL_RST 8'h72
`define GTC_MASK_RST 1'h0

// ==================================================
// Prescale codes and timing
`define GTC_PRE_MAX 4'h7
`define GTC_PRE_AUTO 4'h8
`define GTC_PRE_DL 4'h9
`define GTC_COUNT_FULL 16'hffff

// ==================================================
// Bus answers
`define GTC_RESP_OKAY 2'h0
`define GTC_RESP_SLVERR 2'h2

`endif

// ---- gtc_pkg.sv ----
// Purpose: Types shared by the guard timer files
// Assumes: Nothing beyond the defines header
// Notes: Types only
package gtc_pkg;

    // ==================================================
    // Control register image
    typedef struct packed {
        logic [3:0] pre;
        logic resp;
        logic flag;
        logic run;
        logic unlock;
    } gtc_ctrl_t;

    // ==================================================
    // Latched write request
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] data;
        logic [3:0] strb;
    } gtc_wr_t;

endpackage : gtc_pkg

// ---- gtc_tick_sync.sv ----
// Purpose: Bring the slow input clock into aclk as a one-cycle tick
// Assumes: aclk far faster than the input clock
// Notes: Tick marks each rising edge of the input clock
`timescale 1ns/1ps

module gtc_tick_sync (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic input_clock,
    output logic tick
);

    logic sync1_q;
    logic sync1_d;
    logic sync2_q;
    logic sync2_d;
    logic prev_q;
    logic prev_d;

    // ==================================================
    // Two-stage synchroniser, edge seen after stage two only
    always_comb
    begin
        sync1_d = input_clock;
        sync2_d = sync1_q;
        prev_d = sync2_q;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            prev_q <= 1'b0;
        end
        else
        begin
            sync1_q <= sync1_d;
            sync2_q <= sync2_d;
            prev_q <= prev_d;
        end
    end

    assign tick = sync2_q && !prev_q;

endmodule : gtc_tick_sync

// ---- gtc_guard_timer_control.sv ----
// Purpose: Guard timer with protected control register over AXI4-Lite
// Assumes: aresetn is the external pin reset; aclk 10 MHz
// Notes: Reset requests are one-cycle pulses for the system reset logic
//
// Overview of operation
// - Code 1000 resets the system at once
// - Code 1001 resets into serial download
// - Response clear: expiry resets the system
// - Response set: expiry raises an interrupt
// - Any timeout sets the status flag
// - Flag clears by zero write or pin reset
// - Watchdog reset leaves the flag alone
// - Setting run enables and clears counter; resets set
// - Each run write restarts the timeout
// - Writing run zero stops all timeouts
// - 16-bit counter on input clock, 2^pre*512
// - Control write only right after unlock
`timescale 1ns/1ps
`include "gtc_defines.svh"

module gtc_guard_timer_control (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic [2:0] arprot,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic input_clock,
    output logic irq,
    output logic system_reset_req,
    output logic download_reset_req
);

    // ==================================================
    // Bus slave state
    logic aw_free_q, aw_free_d, w_free_q, w_free_d;
    logic ar_free_q, ar_free_d;
    logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
    logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
    logic [31:0] rdata_q, rdata_d;
    gtc_pkg::gtc_wr_t wr_q, wr_d;
    logic wr_do;

    // ==================================================
    // Timer state
    gtc_pkg::gtc_ctrl_t ctrl_q, ctrl_d, ctrl_wr;
    logic [15:0] count_q, count_d, limit;
    logic sts_q, sts_d, mask_q, mask_d;
    logic irq_q, irq_d, sysrst_q, sysrst_d, dlrst_q, dlrst_d;
    logic tick, expire, wr_ctrl, accept, sel_ok;

    gtc_tick_sync u_tick (
        .aclk(aclk),
        .aresetn(aresetn),
        .input_clock(input_clock),
        .tick(tick)
    );

    // ==================================================
    // Write channel: address and data in either order
    assign wr_do = !aw_free_q && !w_free_q && !bvalid_q;
    assign wr_ctrl = wr_do && (wr_q.addr == `GTC_OFS_CTRL) && wr_q.strb[0];
    assign accept = wr_ctrl && ctrl_q.unlock;
    assign ctrl_wr = gtc_pkg::gtc_ctrl_t'(wr_q.data[7:0]);

    always_comb
    begin
        aw_free_d = aw_free_q;
        w_free_d = w_free_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        wr_d = wr_q;
        if (awvalid && aw_free_q)
        begin
            aw_free_d = 1'b0;
            wr_d.addr = awaddr;
        end
        if (wvalid && w_free_q)
        begin
            w_free_d = 1'b0;
            wr_d.data = wdata;
            wr_d.strb = wstrb;
        end
        if (wr_do)
        begin
            aw_free_d = 1'b1;
            w_free_d = 1'b1;
            bvalid_d = 1'b1;
            bresp_d = `GTC_RESP_SLVERR;
            if (wr_q.addr == `GTC_OFS_CTRL || wr_q.addr == `GTC_OFS_IRQ_STATUS
                || wr_q.addr == `GTC_OFS_IRQ_MASK || wr_q.addr == `GTC_OFS_COUNT)
            begin
                bresp_d = `GTC_RESP_OKAY;
            end
        end
        else if (bvalid_q && bready)
        begin
            bvalid_d = 1'b0;
        end
    end

    // ==================================================
    // Read channel
    always_comb
    begin
        ar_free_d = ar_free_q;
        rvalid_d = rvalid_q;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        if (arvalid && ar_free_q)
        begin
            ar_free_d = 1'b0;
            rvalid_d = 1'b1;
            rresp_d = `GTC_RESP_OKAY;
            case (araddr)
                `GTC_OFS_CTRL: rdata_d = {24'h000000, ctrl_q};
                `GTC_OFS_IRQ_STATUS: rdata_d = {31'h00000000, sts_q};
                `GTC_OFS_IRQ_MASK: rdata_d = {31'h00000000, mask_q};
                `GTC_OFS_COUNT: rdata_d = {16'h0000, count_q};
                default:
                begin
                    rdata_d = 32'h00000000;
                    rresp_d = `GTC_RESP_SLVERR;
                end
            endcase
        end
        else if (rvalid_q && rready)
        begin
            rvalid_d = 1'b0;
            ar_free_d = 1'b1;
        end
    end

    // ==================================================
    // Timeout detection
    // Only codes 0..7 can expire; invalid codes still count but never time out
    assign sel_ok = ctrl_q.pre <= `GTC_PRE_MAX;
    assign limit = `GTC_COUNT_FULL >> (3'd7 - ctrl_q.pre[2:0]);
    assign expire = ctrl_q.run && sel_ok && tick && (count_q == limit);

    // ==================================================
    // Control, counter, interrupt and reset requests
    always_comb
    begin
        ctrl_d = ctrl_q;
        count_d = count_q;
        sts_d = sts_q;
        mask_d = mask_q;
        sysrst_d = 1'b0;
        dlrst_d = 1'b0;
        if (wr_do)
        begin
            // Any other write breaks the unlock sequence
            ctrl_d.unlock = 1'b0;
        end
        if (wr_ctrl && !ctrl_q.unlock && ctrl_wr.unlock)
        begin
            ctrl_d.unlock = 1'b1;
        end
        if (ctrl_q.run && tick)
        begin
            count_d = expire ? 16'h0000 : count_q + 16'h0001;
        end
        if (accept)
        begin
            ctrl_d.pre = ctrl_wr.pre;
            ctrl_d.resp = ctrl_wr.resp;
            ctrl_d.run = ctrl_wr.run;
            if (!ctrl_wr.flag)
            begin
                ctrl_d.flag = 1'b0;
            end
            if (ctrl_wr.run)
            begin
                count_d = 16'h0000;
            end
            if (ctrl_wr.pre == `GTC_PRE_AUTO)
            begin
                sysrst_d = 1'b1;
                ctrl_d.flag = 1'b1;
            end
            if (ctrl_wr.pre == `GTC_PRE_DL)
            begin
                dlrst_d = 1'b1;
                ctrl_d.flag = 1'b1;
            end
        end
        if (wr_do && wr_q.addr == `GTC_OFS_IRQ_MASK && wr_q.strb[0])
        begin
            mask_d = wr_q.data[0];
        end
        if (wr_do && wr_q.addr == `GTC_OFS_IRQ_STATUS && wr_q.strb[0] && wr_q.data[0])
        begin
            sts_d = 1'b0;
        end
        // Set wins over a clear in the same cycle
        if (expire)
        begin
            ctrl_d.flag = 1'b1;
            if (ctrl_q.resp)
            begin
                sts_d = 1'b1;
            end
            else
            begin
                sysrst_d = 1'b1;
            end
        end
        irq_d = sts_d && mask_d;
    end

    // ==================================================
    // Registers; only the pin reset clears them
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_free_q <= 1'b1;
            w_free_q <= 1'b1;
            ar_free_q <= 1'b1;
            bvalid_q <= 1'b0;
            rvalid_q <= 1'b0;
            bresp_q <= `GTC_RESP_OKAY;
            rresp_q <= `GTC_RESP_OKAY;
            rdata_q <= 32'h00000000;
            wr_q <= '0;
            ctrl_q <= gtc_pkg::gtc_ctrl_t'(`GTC_CTRL_RST);
            count_q <= 16'h0000;
            sts_q <= 1'b0;
            mask_q <= `GTC_MASK_RST;
            irq_q <= 1'b0;
            sysrst_q <= 1'b0;
            dlrst_q <= 1'b0;
        end
        else
        begin
            aw_free_q <= aw_free_d;
            w_free_q <= w_free_d;
            ar_free_q <= ar_free_d;
            bvalid_q <= bvalid_d;
            rvalid_q <= rvalid_d;
            bresp_q <= bresp_d;
            rresp_q <= rresp_d;
            rdata_q <= rdata_d;
            wr_q <= wr_d;
            ctrl_q <= ctrl_d;
            count_q <= count_d;
            sts_q <= sts_d;
            mask_q <= mask_d;
            irq_q <= irq_d;
            sysrst_q <= sysrst_d;
            dlrst_q <= dlrst_d;
        end
    end

    assign awready = aw_free_q;
    assign wready = w_free_q;
    assign bvalid = bvalid_q;
    assign bresp = bresp_q;
    assign arready = ar_free_q;
    assign rvalid = rvalid_q;
    assign rdata = rdata_q;
    assign rresp = rresp_q;
    assign irq = irq_q;
    assign system_reset_req = sysrst_q;
    assign download_reset_req = dlrst_q;

    // ==================================================
    // Checks
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence s_accept_code(logic [3:0] code);
        accept && ctrl_wr.pre == code;
    endsequence

    sequence s_expire_resp(logic r);
        expire && ctrl_q.resp == r;
    endsequence

    chk_auto_reset: assert property (s_accept_code(`GTC_PRE_AUTO) |=> sysrst_q && ctrl_q.flag)
        else $error("code 1000 gave no reset");
    chk_download_reset: assert property (s_accept_code(`GTC_PRE_DL) |=> dlrst_q && !sysrst_q)
        else $error("code 1001 gave no download reset");
    chk_expire_reset: assert property (s_expire_resp(1'b0) |=> sysrst_q ##1 !sysrst_q)
        else $error("expiry gave no single reset pulse");
    chk_expire_irq: assert property (s_expire_resp(1'b1) |=> sts_q && !sysrst_q)
        else $error("expiry gave no interrupt");
    chk_flag_set: assert property (expire |=> ctrl_q.flag)
        else $error("timeout did not set flag");
    chk_flag_hold: assert property (ctrl_q.flag && !(accept && !ctrl_wr.flag) |=> ctrl_q.flag)
        else $error("flag lost without zero write");
    chk_run_clear: assert property (accept && ctrl_wr.run |=> count_q == 16'h0000)
        else $error("run write did not clear counter");
    chk_stop_quiet: assert property (!ctrl_q.run && !accept
        |=> count_q == $past(count_q) && !sysrst_q && (!sts_q || $past(sts_q)))
        else $error("timeout while stopped");
    chk_count_step: assert property (ctrl_q.run && tick && !expire && !accept
        |=> count_q == $past(count_q) + 16'h0001)
        else $error("counter did not step on tick");
    chk_locked_write: assert property (wr_ctrl && !ctrl_q.unlock
        |=> ctrl_q.pre == $past(ctrl_q.pre) && ctrl_q.run == $past(ctrl_q.run))
        else $error("locked control write took effect");

endmodule : gtc_guard_timer_control

// ---- tb_gtc_guard_timer_control.sv ----
// Purpose: Self-checking bench for the guard timer over AXI4-Lite
// Assumes: Input clock driven at one twentieth of aclk
// Notes: Flag survival is checked without pulsing aresetn
`timescale 1ns/1ps
`include "gtc_defines.svh"

module tb_gtc_guard_timer_control;
    // ==================================================
    // Stimulus and observation
    logic aclk = 1'b0, aresetn = 1'b0, input_clock = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0] wstrb = 4'hf;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, irq, system_reset_req, download_reset_req;
    logic [1:0] bresp, rresp, rsp;
    logic [31:0] rd, cnt_a;
    int num_errors = 0, num_checks = 0, cyc = 0, sys_cnt = 0, dl_cnt = 0, ic_div = 0, t0, k;

    gtc_guard_timer_control dut_u (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
        .awprot(3'h0), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready), .input_clock(input_clock), .irq(irq),
        .system_reset_req(system_reset_req), .download_reset_req(download_reset_req));

    initial
    begin
        forever #50 aclk = ~aclk;
    end

    // Input clock free-runs; pulse counters catch one-cycle requests
    always @(posedge aclk)
    begin
        cyc <= cyc + 1;
        ic_div <= (ic_div == 9) ? 0 : ic_div + 1;
        if (ic_div == 9)
            input_clock <= ~input_clock;
        if (system_reset_req === 1'b1)
            sys_cnt <= sys_cnt + 1;
        if (download_reset_req === 1'b1)
            dl_cnt <= dl_cnt + 1;
    end

    // ==================================================
    // Shared tasks
    task print_verdict;
        if (num_errors == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : print_verdict

    task give_up;
        num_errors++;
        print_verdict;
    endtask : give_up

    task check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        bit aw_ok, w_ok;
        int n;
        aw_ok = 0;
        w_ok = 0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 100 && !(aw_ok && w_ok); n++)
        begin
            @(posedge aclk);
            if (!aw_ok && awready === 1'b1)
            begin
                aw_ok = 1;
                awvalid <= 1'b0;
            end
            if (!w_ok && wready === 1'b1)
            begin
                w_ok = 1;
                wvalid <= 1'b0;
            end
        end
        for (n = 0; n < 100 && bvalid !== 1'b1; n++)
            @(posedge aclk);
        if (bvalid !== 1'b1)
            give_up;
        r = bresp;
        bready <= 1'b0;
    endtask : axi_write

    task axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        n = 0;
        do
        begin
            @(posedge aclk);
            n++;
        end
        while (arready !== 1'b1 && n < 100);
        arvalid <= 1'b0;
        for (n = 0; n < 100 && rvalid !== 1'b1; n++)
            @(posedge aclk);
        if (rvalid !== 1'b1)
            give_up;
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask : axi_read

    // Unlock then control write, the only accepted sequence
    task prot_write(input logic [7:0] d);
        axi_write(`GTC_OFS_CTRL, 32'h1, rsp);
        axi_write(`GTC_OFS_CTRL, {24'h0, d}, rsp);
        t0 = cyc;
    endtask : prot_write

    task read_chk(input logic [7:0] a, input logic [31:0] exp);
        axi_read(a, rd, rsp);
        check(rd, exp);
    endtask : read_chk

    task wait_cycles(input int n);
        repeat (n) @(posedge aclk);
    endtask : wait_cycles

    // ==================================================
    // Main sequence
    initial
    begin
        wait_cycles(10);
        aresetn <= 1'b1;
        read_chk(`GTC_OFS_CTRL, 32'h72);
        read_chk(`GTC_OFS_IRQ_MASK, 32'h0);
        read_chk(`GTC_OFS_IRQ_STATUS, 32'h0);
        axi_read(8'h10, rd, rsp);
        check(rd, 32'h0);
        check(rsp, `GTC_RESP_SLVERR);
        axi_write(8'h10, 32'h1, rsp);
        check(rsp, `GTC_RESP_SLVERR);
        axi_write(`GTC_OFS_COUNT, 32'hffff, rsp);
        check(rsp, `GTC_RESP_OKAY);
        read_chk(`GTC_OFS_CTRL, 32'h72);
        axi_read(`GTC_OFS_COUNT, rd, rsp);
        check(rd != 32'h0, 1'b1);
        // Unprotected and interrupted sequences are ignored
        axi_write(`GTC_OFS_CTRL, 32'h00, rsp);
        read_chk(`GTC_OFS_CTRL, 32'h72);
        axi_write(`GTC_OFS_CTRL, 32'h1, rsp);
        axi_write(`GTC_OFS_IRQ_MASK, 32'h0, rsp);
        axi_write(`GTC_OFS_CTRL, 32'h00, rsp);
        read_chk(`GTC_OFS_CTRL, 32'h72);
        // Shortest timeout: 512 input ticks of 20 aclk each
        prot_write(8'h02);
        axi_read(`GTC_OFS_COUNT, rd, rsp);
        check(rd < 32'h2, 1'b1);
        k = sys_cnt;
        for (int n = 0; n < 11000 && sys_cnt == k; n++)
            @(posedge aclk);
        check((cyc - t0) >= 10200 && (cyc - t0) <= 10270, 1'b1);
        check(sys_cnt, k + 1);
        read_chk(`GTC_OFS_CTRL, 32'h06);
        read_chk(`GTC_OFS_CTRL, 32'h06);
        // Refreshing in time holds off the reset
        k = sys_cnt;
        repeat (3)
        begin
            wait_cycles(7000);
            prot_write(8'h06);
        end
        check(sys_cnt, k);
        read_chk(`GTC_OFS_CTRL, 32'h06);
        prot_write(8'h02);
        read_chk(`GTC_OFS_CTRL, 32'h02);
        // Interrupt response with mask off, then on, then cleared
        k = sys_cnt;
        prot_write(8'h0a);
        wait_cycles(10400);
        check(irq, 1'b0);
        read_chk(`GTC_OFS_IRQ_STATUS, 32'h1);
        read_chk(`GTC_OFS_CTRL, 32'h0e);
        check(sys_cnt, k);
        axi_write(`GTC_OFS_IRQ_MASK, 32'h1, rsp);
        wait_cycles(3);
        check(irq, 1'b1);
        axi_write(`GTC_OFS_IRQ_STATUS, 32'h1, rsp);
        wait_cycles(3);
        check(irq, 1'b0);
        read_chk(`GTC_OFS_IRQ_STATUS, 32'h0);
        // Stopped timer never expires and holds its count
        prot_write(8'h08);
        axi_read(`GTC_OFS_COUNT, cnt_a, rsp);
        wait_cycles(11000);
        read_chk(`GTC_OFS_COUNT, cnt_a);
        read_chk(`GTC_OFS_IRQ_STATUS, 32'h0);
        read_chk(`GTC_OFS_CTRL, 32'h08);
        // Immediate reset codes
        prot_write(8'h02);
        k = sys_cnt;
        prot_write(8'h82);
        wait_cycles(4);
        check(sys_cnt, k + 1);
        read_chk(`GTC_OFS_CTRL, 32'h86);
        cnt_a = sys_cnt;
        k = dl_cnt;
        prot_write(8'h92);
        wait_cycles(4);
        check(dl_cnt, k + 1);
        check(sys_cnt, cnt_a);
        read_chk(`GTC_OFS_CTRL, 32'h96);
        // Pin reset also clears the flag
        aresetn <= 1'b0;
        wait_cycles(10);
        aresetn <= 1'b1;
        read_chk(`GTC_OFS_CTRL, 32'h72);
        print_verdict;
    end
endmodule : tb_gtc_guard_timer_control
